/* design/cso_regs.sv */
// Calibration status, nonvolatile image, nonvolatile programming and self-test register bank
`timescale 1ns/10ps
// ============================================================================
// Overview of operation
// RULE_01 - Status low nibble holds fine code 0..11
// RULE_02 - Status bits flag calibration and programming activity
// RULE_03 - Raw 24-bit calibration count readable, uncorrected
// RULE_04 - Read-only image of nonvolatile settings bits
// RULE_05 - Nonvolatile settings apply only with programmed flag
// RULE_06 - Clear programmed flag overrides enable bit zero
// RULE_07 - Host writes 4-bit nonvolatile bit address
// RULE_08 - Permit bit first, then strobe issues pulse
// RULE_09 - Self-test result: 16-bit checksum plus busy
// RULE_10 - Calibration strobe write starts calibration, self-test when selected
// RULE_11 - Signed correction added before fine decode
// RULE_12 - Read-only writes ignored, unused bits zero
module cso_regs
    import cso_pkg::*;
#(
    parameter int FINE_SHIFT = 12
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [4:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    output logic [23:0] reg_rdata,
    input wire logic [8:0] meas_adj,
    input wire logic cal_done,
    input wire logic [23:0] cal_count,
    input wire logic self_test_done,
    input wire logic [15:0] self_test_crc,
    input wire logic [14:0] nvm_image,
    input wire logic nvm_program_done,
    input wire logic cfg_enable_bit0,
    output logic cal_start,
    output logic self_test_start,
    output logic rc_self_test_select,
    output logic nvm_program_permit,
    output logic [3:0] nvm_program_addr,
    output logic nvm_program_pulse,
    output logic nvm_program_running,
    output logic enable_effective,
    output logic nvm_settings_apply
);

    if (FINE_SHIFT < 1 || FINE_SHIFT > 20) begin : g_bad_shift
        $error("FINE_SHIFT out of range");
    end

    // ========================================================================
    // Fine code decode
    // ========================================================================
    function automatic logic [3:0] cso_decode(input logic [23:0] raw, input logic [8:0] adj);
        logic signed [25:0] sum;
        logic [25:0] shifted;
        sum = $signed({2'b00, raw}) + ($signed({{17{adj[8]}}, adj}) <<< CSO_ADJ_SHIFT); // RULE_11
        shifted = 26'(sum >>> FINE_SHIFT);
        if (sum < 0) begin
            cso_decode = 4'h0;
        end else if (shifted > 26'(CSO_FINE_CODE_MAX)) begin
            cso_decode = CSO_FINE_CODE_MAX; // RULE_01
        end else begin
            cso_decode = shifted[3:0];
        end
    endfunction : cso_decode

    // ========================================================================
    // State
    // ========================================================================
    cso_state_type s_q;
    cso_state_type s_d;
    logic wr_cal;
    logic wr_nvm_strobe;
    logic nvm_busy;

    assign wr_cal = reg_wr_en && (reg_addr == CSO_CAL_STROBE_ADDR);
    assign wr_nvm_strobe = reg_wr_en && (reg_addr == CSO_NVM_STROBE_ADDR);
    assign nvm_busy = (s_q.nvm_state != CSO_NVM_IDLE);

    always_comb begin
        s_d = s_q;
        s_d.cal_start = 1'b0;
        s_d.self_test_start = 1'b0;
        s_d.nvm_pulse = 1'b0;
        // Register writes; read-only offsets fall through untouched
        if (reg_wr_en) begin // RULE_12
            case (reg_addr)
                CSO_NVM_PERMIT_ADDR: begin
                    s_d.nvm_program_permit = reg_wdata[0];
                end
                CSO_NVM_ADDR_ADDR: begin
                    s_d.nvm_bit_addr = reg_wdata[3:0]; // RULE_07
                end
                CSO_ST_ENABLE_ADDR: begin
                    s_d.rc_self_test_select = reg_wdata[0];
                end
                default: begin
                end
            endcase
        end
        // Calibration: done clears busy, a new strobe wins
        if (cal_done) begin
            s_d.cal_running = 1'b0; // RULE_02
            s_d.raw_count = cal_count; // RULE_03
            s_d.fine_code = cso_decode(cal_count, meas_adj); // RULE_01
        end
        if (wr_cal) begin
            s_d.cal_start = 1'b1; // RULE_10
            s_d.cal_running = 1'b1;
        end
        // Self-test shares the calibration strobe
        if (self_test_done) begin
            s_d.self_test_running = 1'b0; // RULE_09
            s_d.self_test_checksum = self_test_crc;
        end
        if (wr_cal && s_q.rc_self_test_select) begin
            s_d.self_test_start = 1'b1; // RULE_10
            s_d.self_test_running = 1'b1;
        end
        // Nonvolatile bit programming sequence
        case (s_q.nvm_state)
            CSO_NVM_IDLE: begin
                if (wr_nvm_strobe && s_q.nvm_program_permit) begin // RULE_08
                    s_d.nvm_state = CSO_NVM_PULSE;
                    s_d.nvm_pulse = 1'b1;
                end
            end
            CSO_NVM_PULSE: begin
                s_d.nvm_state = nvm_program_done ? CSO_NVM_IDLE : CSO_NVM_WAIT;
            end
            CSO_NVM_WAIT: begin
                if (nvm_program_done) begin
                    s_d.nvm_state = CSO_NVM_IDLE; // RULE_02
                end
            end
            default: begin
                s_d.nvm_state = CSO_NVM_IDLE;
            end
        endcase
        s_d.nvm_running = (s_d.nvm_state != CSO_NVM_IDLE); // RULE_02
        // Programmed flag gates use of stored settings and enable bit zero
        s_d.nvm_apply = nvm_image[CSO_NVM_PRG_FLAG_BIT]; // RULE_05
        s_d.enable_effective = nvm_image[CSO_NVM_PRG_FLAG_BIT] && cfg_enable_bit0; // RULE_06
        // Read path; unused bits zero
        if (reg_rd_en) begin
            s_d.rdata = 24'h000000; // RULE_12
            case (reg_addr)
                CSO_CAL_STATUS_ADDR: begin
                    s_d.rdata[3:0] = s_q.fine_code; // RULE_01
                    s_d.rdata[CSO_STATUS_CAL_BUSY_BIT] = s_q.cal_running; // RULE_02
                    s_d.rdata[CSO_STATUS_NVM_BUSY_BIT] = nvm_busy;
                end
                CSO_CAL_COUNT_ADDR: begin
                    s_d.rdata = s_q.raw_count; // RULE_03
                end
                CSO_NVM_VALUES_ADDR: begin
                    s_d.rdata[CSO_NVM_IMAGE_WIDTH-1:0] = nvm_image; // RULE_04
                end
                CSO_NVM_PERMIT_ADDR: begin
                    s_d.rdata[0] = s_q.nvm_program_permit;
                end
                CSO_NVM_ADDR_ADDR: begin
                    s_d.rdata[3:0] = s_q.nvm_bit_addr;
                end
                CSO_ST_ENABLE_ADDR: begin
                    s_d.rdata[0] = s_q.rc_self_test_select;
                end
                CSO_ST_RESULT_ADDR: begin
                    s_d.rdata[15:0] = s_q.self_test_checksum; // RULE_09
                    s_d.rdata[CSO_ST_BUSY_BIT] = s_q.self_test_running;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.nvm_state <= CSO_NVM_IDLE;
            s_q.nvm_program_permit <= CSO_PERMIT_RESET;
            s_q.nvm_bit_addr <= CSO_BIT_ADDR_RESET;
            s_q.rc_self_test_select <= CSO_ST_SELECT_RESET;
            s_q.self_test_checksum <= CSO_CHECKSUM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign reg_rdata = s_q.rdata;
    assign cal_start = s_q.cal_start;
    assign self_test_start = s_q.self_test_start;
    assign rc_self_test_select = s_q.rc_self_test_select;
    assign nvm_program_permit = s_q.nvm_program_permit;
    assign nvm_program_addr = s_q.nvm_bit_addr;
    assign nvm_program_pulse = s_q.nvm_pulse;
    assign nvm_program_running = s_q.nvm_running;
    assign enable_effective = s_q.enable_effective;
    assign nvm_settings_apply = s_q.nvm_apply;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_fine_range;
        s_q.fine_code <= CSO_FINE_CODE_MAX;
    endproperty
    a_fine_range: assert property (p_fine_range) // RULE_01
        else $error("fine code above 11");

    property p_cal_busy_span;
        wr_cal |=> cal_start && s_q.cal_running ##1 cal_start == $past(wr_cal);
    endproperty
    a_cal_busy_span: assert property (p_cal_busy_span) // RULE_10
        else $error("calibration strobe did not start calibration");

    property p_cal_busy_clear;
        cal_done && !wr_cal |=> !s_q.cal_running && s_q.raw_count == $past(cal_count);
    endproperty
    a_cal_busy_clear: assert property (p_cal_busy_clear) // RULE_02
        else $error("calibration busy or count wrong after done");

    property p_count_stable;
        !cal_done |=> $stable(s_q.raw_count);
    endproperty
    a_count_stable: assert property (p_count_stable) // RULE_03
        else $error("raw count changed without calibration done");

    property p_status_read;
        reg_rd_en && reg_addr == CSO_CAL_STATUS_ADDR |=>
            reg_rdata == {18'h0, $past(nvm_busy),
                          $past(s_q.cal_running), $past(s_q.fine_code)};
    endproperty
    a_status_read: assert property (p_status_read) // RULE_12
        else $error("status read data wrong");

    property p_nvm_pulse;
        wr_nvm_strobe && s_q.nvm_program_permit && !nvm_busy |=>
            nvm_program_pulse && nvm_program_running ##1 !nvm_program_pulse;
    endproperty
    a_nvm_pulse: assert property (p_nvm_pulse) // RULE_08
        else $error("programming pulse not issued");

    property p_nvm_no_permit;
        wr_nvm_strobe && !s_q.nvm_program_permit |=> !nvm_program_pulse;
    endproperty
    a_nvm_no_permit: assert property (p_nvm_no_permit) // RULE_08
        else $error("programming pulse without permit");

    property p_override;
        !nvm_image[CSO_NVM_PRG_FLAG_BIT] |=> !enable_effective && !nvm_settings_apply;
    endproperty
    a_override: assert property (p_override) // RULE_06
        else $error("clear programmed flag did not override");

    property p_self_test;
        self_test_done && !(wr_cal && s_q.rc_self_test_select) |=>
            !s_q.self_test_running && s_q.self_test_checksum == $past(self_test_crc);
    endproperty
    a_self_test: assert property (p_self_test) // RULE_09
        else $error("self-test result not captured");

    property p_st_start;
        wr_cal |=> self_test_start == $past(s_q.rc_self_test_select);
    endproperty
    a_st_start: assert property (p_st_start) // RULE_10
        else $error("self-test start does not follow select");

    property p_nvm_refuse_busy;
        wr_nvm_strobe && nvm_busy |=> !nvm_program_pulse;
    endproperty
    a_nvm_refuse_busy: assert property (p_nvm_refuse_busy) // RULE_08
        else $error("programming pulse while programming running");

    property p_apply;
        nvm_image[CSO_NVM_PRG_FLAG_BIT] |=>
            nvm_settings_apply && enable_effective == $past(cfg_enable_bit0);
    endproperty
    a_apply: assert property (p_apply) // RULE_05
        else $error("programmed flag set but settings not applied");

    property p_rdata_hold;
        !reg_rd_en |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) // RULE_12
        else $error("read data changed without a read");

    property p_permit_write;
        reg_wr_en && reg_addr == CSO_NVM_PERMIT_ADDR |=> nvm_program_permit == $past(reg_wdata[0]);
    endproperty
    a_permit_write: assert property (p_permit_write) // RULE_08
        else $error("programming permit not written");

    property p_addr_write;
        reg_wr_en && reg_addr == CSO_NVM_ADDR_ADDR |=> nvm_program_addr == $past(reg_wdata[3:0]);
    endproperty
    a_addr_write: assert property (p_addr_write) // RULE_07
        else $error("programming bit address not written");

    c_cal: cover property (wr_cal ##[1:20] cal_done);
    c_nvm: cover property (wr_nvm_strobe && s_q.nvm_program_permit ##[2:20] !nvm_busy);
    c_st: cover property (self_test_start ##[1:20] self_test_done);
    c_refuse: cover property (wr_nvm_strobe && nvm_busy);

endmodule : cso_regs

/* design/cso_pkg.sv */
// Package: register map, field positions, reset values and state types of the status bank
package cso_pkg;

    // ==========================================================================
    // Register offsets
    // ==========================================================================
    localparam logic [4:0] CSO_CAL_STROBE_ADDR = 5'h04;
    localparam logic [4:0] CSO_CAL_STATUS_ADDR = 5'h08;
    localparam logic [4:0] CSO_CAL_COUNT_ADDR = 5'h09;
    localparam logic [4:0] CSO_NVM_VALUES_ADDR = 5'h0a;
    localparam logic [4:0] CSO_NVM_PERMIT_ADDR = 5'h0b;
    localparam logic [4:0] CSO_NVM_ADDR_ADDR = 5'h0c;
    localparam logic [4:0] CSO_NVM_STROBE_ADDR = 5'h0d;
    localparam logic [4:0] CSO_ST_ENABLE_ADDR = 5'h0e;
    localparam logic [4:0] CSO_ST_RESULT_ADDR = 5'h0f;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int CSO_STATUS_CAL_BUSY_BIT = 4;
    localparam int CSO_STATUS_NVM_BUSY_BIT = 5;
    localparam int CSO_NVM_PRG_FLAG_BIT = 13;
    localparam int CSO_NVM_IMAGE_WIDTH = 15;
    localparam int CSO_ST_BUSY_BIT = 16;
    localparam logic [3:0] CSO_FINE_CODE_MAX = 4'hb;
    localparam int CSO_ADJ_SHIFT = 10;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic CSO_PERMIT_RESET = 1'h0;
    localparam logic [3:0] CSO_BIT_ADDR_RESET = 4'h0;
    localparam logic CSO_ST_SELECT_RESET = 1'h0;
    localparam logic [15:0] CSO_CHECKSUM_RESET = 16'h0000;

    // ==========================================================================
    // Types
    // ==========================================================================
    typedef enum logic [1:0] {
        CSO_NVM_IDLE = 2'b00,
        CSO_NVM_PULSE = 2'b01,
        CSO_NVM_WAIT = 2'b10
    } cso_nvm_state_type;

    typedef struct packed {
        cso_nvm_state_type nvm_state;
        logic nvm_pulse;
        logic nvm_program_permit;
        logic [3:0] nvm_bit_addr;
        logic cal_running;
        logic cal_start;
        logic [3:0] fine_code;
        logic [23:0] raw_count;
        logic rc_self_test_select;
        logic self_test_running;
        logic self_test_start;
        logic [15:0] self_test_checksum;
        logic [23:0] rdata;
        logic enable_effective;
        logic nvm_apply;
        logic nvm_running;
    } cso_state_type;

endpackage : cso_pkg

/* dv/cso_host_model.sv */
// Host controller model issuing register accesses to the status bank
`timescale 1ns/10ps
module cso_host_model (
    input wire logic clk_sys,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [4:0] reg_addr,
    output logic [23:0] reg_wdata,
    input wire logic [23:0] reg_rdata
);
    // ==========================================================================
    // Access tasks
    // ==========================================================================
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 5'h1f;
        reg_wdata = 24'h000000;
    end

    // Idle address and data are inverted so stale values never look valid
    task automatic access(input logic wr, input logic [4:0] a, input logic [23:0] d);
        @(negedge clk_sys);
        reg_wr_en = wr;
        reg_rd_en = ~wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access

    task automatic write_reg(input logic [4:0] a, input logic [23:0] d);
        access(1'b1, a, d);
    endtask : write_reg

    task automatic read_reg(input logic [4:0] a, output logic [23:0] q);
        access(1'b0, a, 24'h000000);
        q = reg_rdata;
    endtask : read_reg
endmodule : cso_host_model

/* dv/cso_regs_test.sv */
// Self-checking testbench of the calibration status register bank
`timescale 1ns/10ps
module cso_regs_test
    import cso_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en, reg_rd_en;
    logic [4:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata, cal_count, q;
    logic [8:0] meas_adj = 9'h000;
    logic cal_done = 1'b0;
    logic self_test_done = 1'b0;
    logic [15:0] self_test_crc = 16'h0000;
    logic [14:0] nvm_image = 15'h0000;
    logic nvm_program_done = 1'b0;
    logic cfg_enable_bit0 = 1'b0;
    logic cal_start, self_test_start, rc_self_test_select, nvm_program_permit;
    logic [3:0] nvm_program_addr;
    logic [3:0] code = 4'h0;
    logic nvm_program_pulse, nvm_program_running, enable_effective, nvm_settings_apply;
    int failures = 0;
    int num_checks = 0;

    always #20 clk_sys = ~clk_sys;
    initial cal_count = 24'h000000;

    cso_regs cso_regs_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .meas_adj(meas_adj), .cal_done(cal_done),
        .cal_count(cal_count), .self_test_done(self_test_done),
        .self_test_crc(self_test_crc), .nvm_image(nvm_image),
        .nvm_program_done(nvm_program_done), .cfg_enable_bit0(cfg_enable_bit0),
        .cal_start(cal_start), .self_test_start(self_test_start),
        .rc_self_test_select(rc_self_test_select), .nvm_program_permit(nvm_program_permit),
        .nvm_program_addr(nvm_program_addr), .nvm_program_pulse(nvm_program_pulse),
        .nvm_program_running(nvm_program_running), .enable_effective(enable_effective),
        .nvm_settings_apply(nvm_settings_apply));
    cso_host_model cso_host_model_i (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));

    // ==========================================================================
    // Helpers
    // ==========================================================================
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rchk(input logic [4:0] a, input logic [23:0] exp, input string what);
        cso_host_model_i.read_reg(a, q);
        check(what, exp, q);
    endtask : rchk

    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic test_cal(input logic [23:0] cnt, input logic [8:0] adj, input logic [3:0] c);
        meas_adj = adj;
        cso_host_model_i.write_reg(CSO_CAL_STROBE_ADDR, 24'h5a5a5a);
        check("cal_start", 24'h1, {22'h0, self_test_start, cal_start});
        rchk(CSO_CAL_STATUS_ADDR, {20'h1, code}, "status busy");
        check("cal_start end", 24'h0, {23'h0, cal_start});
        @(negedge clk_sys);
        cal_done = 1'b1;
        cal_count = cnt;
        @(negedge clk_sys);
        cal_done = 1'b0;
        cal_count = ~cnt;
        code = c;
        rchk(CSO_CAL_STATUS_ADDR, {20'h0, c}, "fine code");
        rchk(CSO_CAL_COUNT_ADDR, cnt, "raw count");
    endtask : test_cal

    task automatic test_self_test;
        cso_host_model_i.write_reg(CSO_ST_ENABLE_ADDR, 24'hffffff);
        rchk(CSO_ST_ENABLE_ADDR, 24'h1, "select");
        check("select pin", 24'h1, {23'h0, rc_self_test_select});
        cso_host_model_i.write_reg(CSO_CAL_STROBE_ADDR, 24'h000000);
        check("st start", 24'h3, {22'h0, self_test_start, cal_start});
        rchk(CSO_ST_RESULT_ADDR, 24'h010000, "st busy");
        @(negedge clk_sys);
        self_test_done = 1'b1;
        self_test_crc = 16'hbeef;
        cal_done = 1'b1;
        cal_count = 24'h005000;
        meas_adj = 9'h000;
        @(negedge clk_sys);
        self_test_done = 1'b0;
        self_test_crc = 16'h4110;
        cal_done = 1'b0;
        code = 4'h5;
        rchk(CSO_ST_RESULT_ADDR, 24'h00beef, "checksum");
        cso_host_model_i.write_reg(CSO_ST_ENABLE_ADDR, 24'h000000);
    endtask : test_self_test

    task automatic test_nvm;
        cso_host_model_i.write_reg(CSO_NVM_STROBE_ADDR, 24'h000000);
        check("pulse refused", 24'h0, {23'h0, nvm_program_pulse});
        cso_host_model_i.write_reg(CSO_NVM_PERMIT_ADDR, 24'hffffff);
        rchk(CSO_NVM_PERMIT_ADDR, 24'h1, "permit");
        check("permit pin", 24'h1, {23'h0, nvm_program_permit});
        cso_host_model_i.write_reg(CSO_NVM_ADDR_ADDR, 24'hfffff9);
        rchk(CSO_NVM_ADDR_ADDR, 24'h9, "bit addr");
        check("addr pin", 24'h9, {20'h0, nvm_program_addr});
        cso_host_model_i.write_reg(CSO_NVM_STROBE_ADDR, 24'h000000);
        check("pulse", 24'h3, {22'h0, nvm_program_pulse, nvm_program_running});
        rchk(CSO_CAL_STATUS_ADDR, {20'h2, code}, "nvm busy");
        cso_host_model_i.write_reg(CSO_NVM_STROBE_ADDR, 24'h000000);
        check("busy refused", 24'h1, {22'h0, nvm_program_pulse, nvm_program_running});
        @(negedge clk_sys);
        nvm_program_done = 1'b1;
        @(negedge clk_sys);
        nvm_program_done = 1'b0;
        rchk(CSO_CAL_STATUS_ADDR, {20'h0, code}, "nvm idle");
        cso_host_model_i.write_reg(CSO_NVM_PERMIT_ADDR, 24'h000000);
        check("permit off", 24'h0, {23'h0, nvm_program_permit});
    endtask : test_nvm

    task automatic test_image;
        cfg_enable_bit0 = 1'b1;
        nvm_image = 15'h5abc;
        repeat (2) @(negedge clk_sys);
        check("flag clear", 24'h0, {22'h0, enable_effective, nvm_settings_apply});
        rchk(CSO_NVM_VALUES_ADDR, 24'h005abc, "image");
        nvm_image = 15'h7abc;
        repeat (2) @(negedge clk_sys);
        check("flag set", 24'h3, {22'h0, enable_effective, nvm_settings_apply});
        cfg_enable_bit0 = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("enable off", 24'h1, {22'h0, enable_effective, nvm_settings_apply});
    endtask : test_image

    task automatic test_read_only;
        cso_host_model_i.write_reg(CSO_CAL_COUNT_ADDR, 24'h123456);
        rchk(CSO_CAL_COUNT_ADDR, 24'h005000, "count ro");
        cso_host_model_i.write_reg(CSO_ST_RESULT_ADDR, 24'hffffff);
        rchk(CSO_ST_RESULT_ADDR, 24'h00beef, "result ro");
        cso_host_model_i.write_reg(CSO_NVM_VALUES_ADDR, 24'h000000);
        rchk(CSO_NVM_VALUES_ADDR, 24'h007abc, "image ro");
        rchk(CSO_NVM_STROBE_ADDR, 24'h0, "strobe wo");
        rchk(5'h1f, 24'h0, "unmapped");
    endtask : test_read_only

    // ==========================================================================
    // Main sequence and watchdog
    // ==========================================================================
    initial begin
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        rchk(CSO_NVM_PERMIT_ADDR, 24'h0, "permit reset");
        rchk(CSO_ST_RESULT_ADDR, 24'h0, "result reset");
        test_cal(24'h005000, 9'h000, 4'h5);
        test_cal(24'h005000, 9'h1e2, 4'h0);
        test_cal(24'h00c000, 9'h000, 4'hb);
        test_cal(24'h001000, 9'h003, 4'h1);
        test_self_test();
        test_nvm();
        test_image();
        test_read_only();
        end_sim();
    end

    initial begin
        #(40 * 4000);
        failures++;
        end_sim();
    end
endmodule : cso_regs_test
